// ---- hdl/dpc_pkg.sv ----
// Purpose: shared constants for the data prefetch control block
// Assumes: 32-bit addresses, 5-bit hint field
// Notes:   hint codes and cache attribute codes live here
package dpc_pkg;
	localparam int ADDR_W = 32;
	localparam int IMM_W = 16;
	localparam int HINT_W = 5;
	localparam int WAY_W = 2;
	localparam logic [4:0] HINT_LOAD = 5'h00;
	localparam logic [4:0] HINT_STORE = 5'h01;
	localparam logic [4:0] HINT_LOAD_STREAMED = 5'h04;
	localparam logic [4:0] HINT_STORE_STREAMED = 5'h05;
	localparam logic [4:0] HINT_LOAD_RETAINED = 5'h06;
	localparam logic [4:0] HINT_STORE_RETAINED = 5'h07;
	localparam logic [4:0] HINT_WB_INVALIDATE = 5'h19;
	localparam logic [4:0] HINT_WHOLE_LINE_WRITE = 5'h1e;
	// access type codes from translation
	localparam logic [2:0] CCA_UNCACHED = 3'h2;
	// fill class placed in the cache with each line
	typedef enum logic [1:0] {
		DPC_FILL_NORMAL,
		DPC_FILL_STREAMED,
		DPC_FILL_RETAINED
	} dpc_fill_e;
endpackage
`default_nettype wire

// ---- hdl/dpc_hint_decode.sv ----
// Purpose: decode the prefetch usage hint
// Assumes: hint is a plain 5-bit field
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module dpc_hint_decode
(
	// hint in
	input  wire logic [4:0] hint,
	// decoded
	output logic            hint_valid,
	output logic            hint_store,
	output dpc_pkg::dpc_fill_e fill_class
);
	always_comb
	begin
		hint_valid = 1'b1;
		hint_store = 1'b0;
		fill_class = dpc_pkg::DPC_FILL_NORMAL;
		unique case (hint)
			dpc_pkg::HINT_LOAD: ; // [RULE10]
			dpc_pkg::HINT_STORE: hint_store = 1'b1; // [RULE10]
			dpc_pkg::HINT_LOAD_STREAMED:
				fill_class = dpc_pkg::DPC_FILL_STREAMED; // [RULE11]
			dpc_pkg::HINT_STORE_STREAMED:
			begin
				hint_store = 1'b1;
				fill_class = dpc_pkg::DPC_FILL_STREAMED; // [RULE11]
			end
			dpc_pkg::HINT_LOAD_RETAINED:
				fill_class = dpc_pkg::DPC_FILL_RETAINED; // [RULE12]
			dpc_pkg::HINT_STORE_RETAINED:
			begin
				hint_store = 1'b1;
				fill_class = dpc_pkg::DPC_FILL_RETAINED; // [RULE12]
			end
			// 25, 30 and every reserved code fall here
			default: hint_valid = 1'b0; // [RULE13] [RULE7]
		endcase
	end
endmodule // dpc_hint_decode
`default_nettype wire

// ---- hdl/dpc_top.sv ----
// Purpose: prefetch issue and fill control for the data cache
// Assumes: translation and cache lookup answer in the issue cycle
// Notes:   one outstanding read at a time; never stalls the pipe
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1: address is base register plus sign-extended 16-bit immediate.
// RULE2: prefetch never changes architectural state.
// RULE3: addressing faults are suppressed and no data moves.
// RULE4: invisible actions such as dirty writeback may still happen.
// RULE5: no memory operation is issued to uncached locations.
// RULE6: bus access type comes from the address translation.
// RULE7: reserved hint, 25, fault, uncached, hit or busy means no-op.
// RULE8: otherwise an external bus read is started.
// RULE9: pipeline never stalls waiting for prefetch data.
// RULE10: hint 0 fetches for load, hint 1 fetches for store.
// RULE11: hints 4 and 5 fill streamed, never evicting retained lines.
// RULE12: hints 6 and 7 fill retained, safe from streamed fills.
// RULE13: hints 2-3, 8-24, 26-31 are treated as no-ops.
// RULE14: prefetch never raises a translation exception.
// RULE15: mapped address prefetches only on a translation hit.
// RULE16: linked load raises only refill, invalid, address, reserved.
// RULE17: returned data goes to the cache line only, never a register.
module dpc_top
#(
	parameter int ADDR_W = dpc_pkg::ADDR_W
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// issue from pipeline
	input  wire logic              data_prefetch_instruction_valid,
	input  wire logic [4:0]        data_prefetch_instruction_hint,
	input  wire logic [ADDR_W-1:0] base_value,
	input  wire logic [15:0]       imm_offset,
	// linked load exception inputs
	input  wire logic              ll_valid,
	input  wire logic              ll_tlb_refill,
	input  wire logic              ll_tlb_invalid,
	input  wire logic              ll_addr_error,
	input  wire logic              ll_reserved_instr,
	input  wire logic              ll_bus_error,
	// translation
	output logic [ADDR_W-1:0]      xlat_vaddr,
	input  wire logic              xlat_mapped,
	input  wire logic              xlat_hit,
	input  wire logic              xlat_fault,
	input  wire logic [ADDR_W-1:0] xlat_paddr,
	input  wire logic [2:0]        xlat_cca,
	// cache and load unit state
	input  wire logic              cache_hit,
	input  wire logic              load_outstanding,
	// exception outputs
	output logic                   data_prefetch_instruction_exception,
	output logic                   ll_exception,
	// pipeline
	output logic                   pipe_stall,
	// external bus read
	output logic                   bus_req,
	output logic [ADDR_W-1:0]      bus_addr,
	output logic [2:0]             bus_cca,
	output logic                   bus_for_store,
	input  wire logic              bus_ack,
	input  wire logic              bus_rvalid,
	input  wire logic              bus_rlast,
	input  wire logic [31:0]       bus_rdata,
	// cache fill
	output logic                   fill_we,
	output logic [31:0]            fill_data,
	output logic [ADDR_W-1:0]      fill_addr,
	output dpc_pkg::dpc_fill_e     fill_class,
	output logic                   fill_own,
	output logic                   fill_done,
	output logic                   gpr_we,
	output logic                   data_prefetch_instruction_busy
);
	initial
	begin
		if (ADDR_W < 17)
			$error("address too narrow for the offset");
	end

	typedef enum logic [1:0] {DPC_IDLE, DPC_REQ, DPC_FILL} dpc_state_e;

	logic               hint_valid;
	logic               hint_store;
	dpc_pkg::dpc_fill_e hint_class;
	logic               issue;

	dpc_hint_decode u_hint
	(
		.hint       (data_prefetch_instruction_hint),
		.hint_valid (hint_valid),
		.hint_store (hint_store),
		.fill_class (hint_class)
	);

	// effective address, wraps modulo 2^ADDR_W
	always_comb
		xlat_vaddr = base_value
			+ {{(ADDR_W-16){imm_offset[15]}}, imm_offset}; // [RULE1]

	// faults are swallowed, so only the issue decision sees them
	always_comb
	begin
		issue = data_prefetch_instruction_valid & hint_valid // [RULE7] [RULE13]
			& ~xlat_fault // [RULE3]
			& ~(xlat_mapped & ~xlat_hit) // [RULE15]
			& (xlat_cca != dpc_pkg::CCA_UNCACHED) // [RULE5]
			& ~cache_hit & ~load_outstanding; // [RULE7]
	end

	assign data_prefetch_instruction_exception = 1'b0; // [RULE14] [RULE3] [RULE2]
	assign pipe_stall = 1'b0; // [RULE9]
	assign gpr_we = 1'b0; // [RULE17] [RULE2]
	// a dirty victim writeback is the cache's own business [RULE4]

	// linked load: bus error and others never escape
	assign ll_exception = ll_valid & (ll_tlb_refill | ll_tlb_invalid
		| ll_addr_error | ll_reserved_instr); // [RULE16]

	dpc_state_e          state;
	dpc_state_e          next_state;
	logic [ADDR_W-1:0]   next_bus_addr;
	logic [2:0]          next_bus_cca;
	logic                next_bus_for_store;
	dpc_pkg::dpc_fill_e  next_fill_class;
	logic                next_fill_we;
	logic [31:0]         next_fill_data;
	logic [ADDR_W-1:0]   next_fill_addr;
	logic                next_fill_done;

	always_comb
	begin
		next_state = state;
		next_bus_addr = bus_addr;
		next_bus_cca = bus_cca;
		next_bus_for_store = bus_for_store;
		next_fill_class = fill_class;
		next_fill_we = 1'b0;
		next_fill_data = fill_data;
		next_fill_addr = fill_addr;
		next_fill_done = 1'b0;
		unique case (state)
			DPC_IDLE:
				if (issue)
				begin
					next_state = DPC_REQ; // [RULE8]
					next_bus_addr = xlat_paddr;
					next_bus_cca = xlat_cca; // [RULE6]
					next_bus_for_store = hint_store; // [RULE10]
					next_fill_class = hint_class; // [RULE11] [RULE12]
					next_fill_addr = xlat_paddr;
				end
			DPC_REQ:
				if (bus_ack)
					next_state = DPC_FILL;
			DPC_FILL:
				if (bus_rvalid)
				begin
					next_fill_we = 1'b1; // [RULE17]
					next_fill_data = bus_rdata;
					next_fill_addr = fill_addr + ADDR_W'(4);
					if (bus_rlast)
					begin
						next_fill_done = 1'b1;
						next_state = DPC_IDLE;
					end
				end
		endcase
	end

	// fill_addr already points at the next beat when fill_we is seen,
	// so the cache subtracts one word; no separate beat copy is kept
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= DPC_IDLE;
			bus_addr <= '0;
			bus_cca <= 3'h0;
			bus_for_store <= 1'b0;
			fill_class <= dpc_pkg::DPC_FILL_NORMAL;
			fill_we <= 1'b0;
			fill_data <= 32'h0;
			fill_addr <= '0;
			fill_done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bus_addr <= next_bus_addr;
			bus_cca <= next_bus_cca;
			bus_for_store <= next_bus_for_store;
			fill_class <= next_fill_class;
			fill_we <= next_fill_we;
			fill_data <= next_fill_data;
			fill_addr <= next_fill_addr;
			fill_done <= next_fill_done;
		end
	end

	assign bus_req = (state == DPC_REQ); // [RULE8]
	assign data_prefetch_instruction_busy = (state != DPC_IDLE);
	// store-intent fills take ownership of the line
	assign fill_own = bus_for_store; // [RULE10]
endmodule // dpc_top
`default_nettype wire

// ---- testbench/dpc_top_sva.sv ----
// Purpose: port checks for dpc_top
// Assumes: one clock, async active-low reset
// Notes:   bound into every dpc_top
`timescale 1ns/1ns
`default_nettype none
module dpc_top_sva
#(
	parameter int ADDR_W = 32
)
(
	input wire logic clk, reset_n, data_prefetch_instruction_valid, data_prefetch_instruction_busy, bus_req, xlat_fault,
	input wire logic xlat_mapped, xlat_hit, cache_hit, load_outstanding,
	input wire logic bus_ack, bus_rvalid, bus_rlast, fill_we, fill_done,
	input wire logic bus_for_store, data_prefetch_instruction_exception, pipe_stall, gpr_we,
	input wire logic [4:0] data_prefetch_instruction_hint,
	input wire logic [2:0] xlat_cca, bus_cca,
	input wire logic [31:0] bus_rdata, fill_data,
	input wire logic [ADDR_W-1:0] xlat_paddr, bus_addr
);
	logic go;
	// hints 0,1,4-7 only; every other code is a silent no-op
	assign go = data_prefetch_instruction_valid && !data_prefetch_instruction_busy && data_prefetch_instruction_hint[4:3] == 2'h0
		&& data_prefetch_instruction_hint[2:1] != 2'h1 && !xlat_fault && !(xlat_mapped && !xlat_hit)
		&& xlat_cca != dpc_pkg::CCA_UNCACHED && !cache_hit && !load_outstanding;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_issue_read: assert property (go |=> bus_req && bus_addr == $past(xlat_paddr)
		&& bus_cca == $past(xlat_cca) && bus_for_store == $past(data_prefetch_instruction_hint[0]))
		else $error("prefetch read not issued as taken");
	a_noop_drop: assert property (data_prefetch_instruction_valid && !data_prefetch_instruction_busy && !go |=> !bus_req)
		else $error("no-op prefetch started a bus read");
	a_req_hold: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
		else $error("bus request dropped before ack");
	a_fill_word: assert property (bus_rvalid |=> fill_we && fill_data == $past(bus_rdata))
		else $error("returned word not written to cache");
	a_done_idle: assert property (bus_rvalid && bus_rlast |=> fill_done ##1 !data_prefetch_instruction_busy)
		else $error("fill did not finish");
	a_no_exc: assert property (!data_prefetch_instruction_exception)
		else $error("prefetch raised an exception");
	a_no_stall: assert property (!pipe_stall)
		else $error("pipeline stalled");
	a_no_gpr: assert property (!gpr_we)
		else $error("register written");
	cover property (go);
	cover property (data_prefetch_instruction_valid && data_prefetch_instruction_busy);
	cover property (bus_rvalid && bus_rlast);
endmodule // dpc_top_sva
bind dpc_top dpc_top_sva #(.ADDR_W(ADDR_W)) i_sva (.clk, .reset_n, .data_prefetch_instruction_valid,
	.data_prefetch_instruction_busy, .bus_req, .xlat_fault, .xlat_mapped, .xlat_hit, .cache_hit,
	.load_outstanding, .bus_ack, .bus_rvalid, .bus_rlast, .fill_we, .fill_done,
	.bus_for_store, .data_prefetch_instruction_exception, .pipe_stall, .gpr_we, .data_prefetch_instruction_hint,
	.xlat_cca, .bus_cca, .bus_rdata, .fill_data, .xlat_paddr, .bus_addr);
`default_nettype wire

// ---- testbench/dpc_bus_model.sv ----
// Purpose: memory bus answering one-beat prefetch reads
// Assumes: ack after dly cycles, then one last beat
// Notes:   idle data shows the inverse word, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module dpc_bus_model
(
	input  wire logic        clk,
	input  wire logic        bus_req,
	input  wire logic [1:0]  dly,
	input  wire logic [31:0] rd_word,
	output logic             bus_ack,
	output logic             bus_rvalid,
	output logic             bus_rlast,
	output logic [31:0]      bus_rdata
);
	initial
	begin
		{bus_ack, bus_rvalid, bus_rlast, bus_rdata} = '0;
		forever
		begin
			@(posedge clk);
			#2 bus_rdata = ~rd_word;
			if (bus_req)
			begin
				repeat (dly) @(posedge clk);
				#2 bus_ack = 1'b1;
				@(posedge clk);
				#2 {bus_ack, bus_rvalid, bus_rlast, bus_rdata} = {3'h3, rd_word};
				@(posedge clk);
				#2 {bus_rvalid, bus_rlast, bus_rdata} = {2'h0, ~rd_word};
			end
		end
	end
endmodule // dpc_bus_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: random and corner prefetches through dpc_top
// Assumes: bus model answers every read
// Notes:   all 32 hints run first with fault, cache hit and load outstanding cleared
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, reset_n, data_prefetch_instruction_valid, ll_valid, ll_tlb_refill, ll_tlb_invalid;
	logic ll_addr_error, ll_reserved_instr, ll_bus_error, xlat_mapped, xlat_hit;
	logic xlat_fault, cache_hit, load_outstanding, data_prefetch_instruction_exception, ll_exception;
	logic pipe_stall, bus_req, bus_for_store, bus_ack, bus_rvalid, bus_rlast;
	logic fill_we, fill_own, fill_done, gpr_we, data_prefetch_instruction_busy, go;
	logic [4:0] data_prefetch_instruction_hint;
	logic [2:0] xlat_cca, bus_cca;
	logic [1:0] dly;
	logic [15:0] imm_offset;
	logic [31:0] base_value, xlat_vaddr, xlat_paddr, bus_addr, bus_rdata;
	logic [31:0] fill_data, fill_addr, rd_word, seed, r;
	dpc_pkg::dpc_fill_e fill_class;
	int error_cnt, n_compared, cyc, k;
	dpc_top i_dut (.clk, .reset_n, .data_prefetch_instruction_valid, .data_prefetch_instruction_hint, .base_value,
		.imm_offset, .ll_valid, .ll_tlb_refill, .ll_tlb_invalid, .ll_addr_error,
		.ll_reserved_instr, .ll_bus_error, .xlat_vaddr, .xlat_mapped, .xlat_hit,
		.xlat_fault, .xlat_paddr, .xlat_cca, .cache_hit, .load_outstanding,
		.data_prefetch_instruction_exception, .ll_exception, .pipe_stall, .bus_req, .bus_addr,
		.bus_cca, .bus_for_store, .bus_ack, .bus_rvalid, .bus_rlast, .bus_rdata,
		.fill_we, .fill_data, .fill_addr, .fill_class, .fill_own, .fill_done,
		.gpr_we, .data_prefetch_instruction_busy);
	dpc_bus_model i_bus (.clk, .bus_req, .dly, .rd_word, .bus_ack, .bus_rvalid,
		.bus_rlast, .bus_rdata);
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	initial
	begin
		seed = 32'h41;
		{reset_n, data_prefetch_instruction_valid, ll_valid, ll_tlb_refill, ll_tlb_invalid} = '0;
		{ll_addr_error, ll_reserved_instr, ll_bus_error, xlat_mapped} = '0;
		{xlat_hit, xlat_fault, cache_hit, load_outstanding, data_prefetch_instruction_hint} = '0;
		{xlat_cca, dly, imm_offset, base_value, xlat_paddr, rd_word} = '0;
		repeat (4) @(posedge clk);
		#2 reset_n = 1'b1;
		for (int i = 0; i < 128; i++)
		begin
			r = xs();
			{xlat_fault, xlat_mapped, xlat_hit} = {r[3:0] == 0, r[4], r[7:5] != 0};
			{cache_hit, load_outstanding} = {r[11:8] == 0, r[15:12] == 0};
			{xlat_cca, imm_offset, dly} = {r[18:16], r[31:16], r[31], r[0]};
			data_prefetch_instruction_hint = r[19] ? {2'h0, r[22:20]} : r[24:20];
			{ll_valid, ll_tlb_refill, ll_tlb_invalid, ll_addr_error,
				ll_reserved_instr, ll_bus_error} = r[30:25];
			if (i < 32)
				{xlat_fault, cache_hit, load_outstanding, data_prefetch_instruction_hint} = {3'h0, i[4:0]};
			{base_value, xlat_paddr, rd_word} = {xs(), xs(), xs()};
			go = data_prefetch_instruction_hint[4:3] == 2'h0 && data_prefetch_instruction_hint[2:1] != 2'h1 && !xlat_fault
				&& !(xlat_mapped && !xlat_hit) && !cache_hit && !load_outstanding
				&& xlat_cca != dpc_pkg::CCA_UNCACHED;
			// held two cycles so the second lands while busy and must drop
			data_prefetch_instruction_valid = 1'b1;
			#1 chk("vaddr", xlat_vaddr, base_value + {{16{imm_offset[15]}}, imm_offset});
			chk("ll_exc", ll_exception, ll_valid & (ll_tlb_refill | ll_tlb_invalid | ll_addr_error | ll_reserved_instr));
			repeat (2) @(posedge clk);
			#2 data_prefetch_instruction_valid = 1'b0;
			for (k = 0; go && fill_we !== 1'b1 && k < 12; k++)
				@(posedge clk) #2;
			if (go)
			begin
				chk("fill_data", fill_data, rd_word);
				chk("fill_class", fill_class, data_prefetch_instruction_hint[2] ? {data_prefetch_instruction_hint[1], !data_prefetch_instruction_hint[1]} : 2'h0);
				chk("fill_own", fill_own, data_prefetch_instruction_hint[0]);
				chk("fill_addr", fill_addr, xlat_paddr + 32'h4);
			end
			@(posedge clk) #2;
			chk("bus_req", bus_req, 1'b0);
			chk("data_prefetch_instruction_busy", data_prefetch_instruction_busy, 1'b0);
		end
		end_sim();
	end
endmodule // testbench
`default_nettype wire
